//--- shared/oss_pkg.sv
package oss_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int OSS_FRAME_BITS = 16;
    localparam int OSS_CHANNELS = 8;
    localparam int OSS_CNT_W = 5;
    localparam int OSS_CMD_OUT_LSB = 0;
    localparam int OSS_CMD_OLD_LSB = 8;
    localparam logic [15:0] OSS_CMD_RESET = 16'h0000;
    localparam logic [7:0] OSS_STATUS_PAD = 8'h00;

    // ------------------------------------------------------------------
    // Timing, system clock 25 MHz
    // ------------------------------------------------------------------
    localparam int OSS_CLK_MHZ = 25;
    localparam int OSS_FAULT_MIN_US = 100;
    localparam int OSS_FAULT_MAX_US = 300;
    localparam int OSS_POR_US = 100;
    localparam int OSS_FAULT_MIN_CYC = OSS_FAULT_MIN_US * OSS_CLK_MHZ;
    localparam int OSS_FAULT_MAX_CYC = OSS_FAULT_MAX_US * OSS_CLK_MHZ;
    // Filter length: midway in the allowed window.
    localparam int OSS_FAULT_CYC = (OSS_FAULT_MIN_CYC + OSS_FAULT_MAX_CYC) / 2;
    localparam int OSS_POR_CYC = OSS_POR_US * OSS_CLK_MHZ;
    localparam int OSS_GAP_CYC = OSS_FAULT_MAX_CYC + 1;
    localparam int OSS_SCK_HALF = 2;
    localparam int OSS_TIMER_W = 16;

    // ------------------------------------------------------------------
    // Host register map (Wishbone byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] OSS_REG_CMD = 4'h0;
    localparam logic [3:0] OSS_REG_CTRL = 4'h4;
    localparam logic [3:0] OSS_REG_STATUS = 4'h8;
    localparam int OSS_CTRL_START_BIT = 0;
    localparam int OSS_CTRL_EN_BIT = 1;
    localparam int OSS_STAT_BUSY_BIT = 16;
    localparam int OSS_STAT_DONE_BIT = 17;

endpackage : oss_pkg

//--- shared/oss_link_if.sv
`timescale 1ns/1ns
interface oss_link_if;
    logic sel_n;
    logic sck;
    logic serial_cmd_in;
    logic sdo;
    logic sdo_oe;
    logic enable;
    logic sdo_wire;

    // Tri-state resolved here: a parked line reads low.
    assign sdo_wire = sdo_oe ? sdo : 1'b0;

    modport device (
        input sel_n,
        input sck,
        input serial_cmd_in,
        input enable,
        output sdo,
        output sdo_oe
    );

    modport host (
        output sel_n,
        output sck,
        output serial_cmd_in,
        output enable,
        input sdo_wire
    );
endinterface : oss_link_if

//--- hdl/oss_fault_filter.sv
`timescale 1ns/1ns
module oss_fault_filter
    import oss_pkg::*;
#(
    parameter int HOLD_CYC = OSS_FAULT_CYC
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Raw and qualified fault
    input wire logic raw_fault_in,
    output logic fault_out
);

    // ------------------------------------------------------------------
    // Persistence counter
    // ------------------------------------------------------------------
    logic [OSS_TIMER_W-1:0] cnt_q;
    logic [OSS_TIMER_W-1:0] cnt_d;
    logic fault_q;
    logic fault_d;
    wire logic at_limit = (cnt_q == OSS_TIMER_W'(HOLD_CYC - 1));

    // A glitch shorter than the hold window restarts the count.
    assign cnt_d = !raw_fault_in ? '0 : (at_limit ? cnt_q : cnt_q + 1'b1);
    assign fault_d = raw_fault_in & (at_limit | fault_q);

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            cnt_q <= '0;
            fault_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            fault_q <= fault_d;
        end
    end

    assign fault_out = fault_q;

endmodule : oss_fault_filter

//--- hdl/oss_device.sv
`timescale 1ns/1ns
// Contract
// - Select low drives output, allows exchange.
// - Command applied only at select rise.
// - Host lowers select only with clock low.
// - Input sampled on each falling clock edge.
// - Output advances on each rising edge.
// - Clock low at every select transition.
// - Host parks clock low when idle.
// - Select high: ignore pins, output tri-state.
// - One turns channel on, zero off.
// - Host sends detect bits, then channels descending.
// - Exactly sixteen bits form a command; the device also applies longer frames, keeping their last sixteen bits.
// - Faulted channel reads one, healthy zero.
// - Detect off and channel off reads zero.
// - First eight status bits are zero.
// - Both words shift MSB first.
// - Fault must persist 100 to 300 us.
// - Host spaces frames over 300 us.
// - Host waits 100 us after enable.
// - Host clock about 4 MHz; the host here runs it at 6.25 MHz (four system clocks per period).
// - Bits 0-7 channels, 8-15 detect current.
// - Enable low clears all; rise resets.
module oss_device
    import oss_pkg::*;
#(
    parameter int FAULT_CYC = OSS_FAULT_CYC
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Link
    oss_link_if.device link,
    // Power stage side
    input wire logic [OSS_CHANNELS-1:0] open_fault_in,
    input wire logic [OSS_CHANNELS-1:0] short_fault_in,
    output logic [OSS_CHANNELS-1:0] chan_on_out,
    output logic [OSS_CHANNELS-1:0] detect_on_out
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic sel_n_prev_q;
    logic sck_prev_q;
    logic en_prev_q;

    // Two flops on every pin; only the second stage feeds logic.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            meta_q <= 4'h1;
            sync_q <= 4'h1;
            sel_n_prev_q <= 1'b1;
            sck_prev_q <= 1'b0;
            en_prev_q <= 1'b0;
        end else begin
            meta_q <= {link.enable, link.serial_cmd_in, link.sck, link.sel_n};
            sync_q <= meta_q;
            sel_n_prev_q <= sync_q[0];
            sck_prev_q <= sync_q[1];
            en_prev_q <= sync_q[3];
        end
    end

    wire logic sel_n_s = sync_q[0];
    wire logic sck_s = sync_q[1];
    wire logic din_s = sync_q[2];
    wire logic en_s = sync_q[3];
    wire logic sel_fall = sel_n_prev_q & ~sel_n_s;
    wire logic sel_rise = ~sel_n_prev_q & sel_n_s;
    wire logic sck_rise = ~sck_prev_q & sck_s & ~sel_n_s;
    wire logic sck_fall = sck_prev_q & ~sck_s & ~sel_n_s;
    // Enable low or its rising edge acts as a local power-on reset.
    wire logic local_rst = srst_in | ~en_s | (en_s & ~en_prev_q);

    // ------------------------------------------------------------------
    // Fault qualification
    // ------------------------------------------------------------------
    logic [OSS_CHANNELS-1:0] fault_q;
    logic [OSS_CHANNELS-1:0] status_now;
    logic [OSS_CMD_OLD_LSB-1:0] chan_q;
    logic [OSS_CHANNELS-1:0] detect_q;

    genvar gi;
    generate
        for (gi = 0; gi < OSS_CHANNELS; gi++) begin : g_ch
            wire logic raw = open_fault_in[gi] | short_fault_in[gi];
            oss_fault_filter #(
                .HOLD_CYC(FAULT_CYC)
            ) u_filt (
                .clk_sys_in(clk_sys_in),
                .srst_in(local_rst),
                .raw_fault_in(raw),
                .fault_out(fault_q[gi])
            );
            // Detect current off hides faults on an off channel.
            assign status_now[gi] = fault_q[gi] & (chan_q[gi] | detect_q[gi]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Shift registers
    // ------------------------------------------------------------------
    logic [OSS_FRAME_BITS-1:0] rx_q;
    logic [OSS_FRAME_BITS-1:0] tx_q;
    logic [OSS_CNT_W-1:0] cnt_q;
    logic sdo_q;
    logic [OSS_FRAME_BITS-1:0] tx_d;
    logic sdo_d;

    // Snapshot at select fall, MSB on the pin at once.
    assign tx_d = sel_fall ? {OSS_STATUS_PAD, status_now} :
                  sck_rise ? {tx_q[OSS_FRAME_BITS-2:0], 1'b0} : tx_q;
    assign sdo_d = sel_fall ? OSS_STATUS_PAD[7] :
                   sck_rise ? tx_q[OSS_FRAME_BITS-2] : sdo_q;

    always_ff @(posedge clk_sys_in) begin
        if (local_rst) begin
            rx_q <= OSS_CMD_RESET;
            tx_q <= '0;
            cnt_q <= '0;
            sdo_q <= 1'b0;
        end else begin
            tx_q <= tx_d;
            sdo_q <= sdo_d;
            if (sel_fall) begin
                cnt_q <= '0;
            end else if (sck_fall) begin
                rx_q <= {rx_q[OSS_FRAME_BITS-2:0], din_s};
                cnt_q <= (cnt_q == OSS_CNT_W'(OSS_FRAME_BITS)) ? cnt_q : cnt_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Command apply
    // ------------------------------------------------------------------
    // Short frames are dropped so a partial word never reaches the outputs.
    wire logic apply = sel_rise & (cnt_q == OSS_CNT_W'(OSS_FRAME_BITS));

    always_ff @(posedge clk_sys_in) begin
        if (local_rst) begin
            chan_q <= OSS_CMD_RESET[OSS_CMD_OLD_LSB-1:OSS_CMD_OUT_LSB];
            detect_q <= OSS_CMD_RESET[OSS_FRAME_BITS-1:OSS_CMD_OLD_LSB];
        end else if (apply) begin
            chan_q <= rx_q[OSS_CMD_OLD_LSB-1:OSS_CMD_OUT_LSB];
            detect_q <= rx_q[OSS_FRAME_BITS-1:OSS_CMD_OLD_LSB];
        end
    end

    assign chan_on_out = chan_q;
    assign detect_on_out = detect_q;
    assign link.sdo = sdo_q;
    assign link.sdo_oe = ~sel_n_s & en_s;

endmodule : oss_device

//--- hdl/oss_host.sv
`timescale 1ns/1ns
module oss_host
    import oss_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Link
    oss_link_if.host link
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        IDLE = 3'b001,
        SHIFT = 3'b010,
        GAP = 3'b100
    } oss_state_type;

    oss_state_type st_q;
    logic [15:0] cmd_q;
    logic en_q;
    logic done_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [15:0] rxd_q;
    logic [15:0] txs_q;
    logic [OSS_TIMER_W-1:0] tmr_q;
    logic [OSS_CNT_W-1:0] bit_q;
    logic [1:0] ph_q;
    logic sck_q;
    logic sel_n_q;
    logic [1:0] sdo_sync_q;

    wire logic req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire logic wr = req & wb_we_i;
    wire logic wr_cmd = wr & (wb_adr_i == OSS_REG_CMD);
    wire logic wr_ctrl = wr & (wb_adr_i == OSS_REG_CTRL);
    wire logic start = wr_ctrl & wb_sel_i[0] & wb_dat_i[OSS_CTRL_START_BIT];
    wire logic busy = (st_q != IDLE);
    wire logic [31:0] rsel = (wb_adr_i == OSS_REG_CMD) ? {16'h0000, cmd_q} :
                             (wb_adr_i == OSS_REG_CTRL) ? {30'h0, en_q, 1'b0} :
                             (wb_adr_i == OSS_REG_STATUS) ?
                             {14'h0, done_q, busy, rxd_q} : 32'h0000_0000;

    // Ack is one cycle after the request; unmapped reads return zero.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            ack_q <= 1'b0;
            rdat_q <= '0;
            cmd_q <= '0;
            en_q <= 1'b0;
        end else begin
            ack_q <= req;
            rdat_q <= rsel;
            if (wr_cmd && wb_sel_i[0]) cmd_q[7:0] <= wb_dat_i[7:0];
            if (wr_cmd && wb_sel_i[1]) cmd_q[15:8] <= wb_dat_i[15:8];
            if (wr_ctrl && wb_sel_i[0]) en_q <= wb_dat_i[OSS_CTRL_EN_BIT];
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ------------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------------
    // Phases: 0 clock low, 2 clock high; sampling on our falling edge.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            st_q <= IDLE;
            sck_q <= 1'b0;
            sel_n_q <= 1'b1;
            txs_q <= '0;
            rxd_q <= '0;
            bit_q <= '0;
            ph_q <= '0;
            tmr_q <= '0;
            done_q <= 1'b0;
            sdo_sync_q <= '0;
        end else begin
            sdo_sync_q <= {sdo_sync_q[0], link.sdo_wire};
            if (!en_q) tmr_q <= OSS_TIMER_W'(OSS_POR_CYC);
            else if (tmr_q != '0 && st_q != SHIFT) tmr_q <= tmr_q - 1'b1;
            unique case (st_q)
                IDLE: begin
                    sck_q <= 1'b0;
                    if (start && en_q && tmr_q == '0) begin
                        st_q <= SHIFT;
                        sel_n_q <= 1'b0;
                        txs_q <= cmd_q;
                        bit_q <= '0;
                        ph_q <= '0;
                        done_q <= 1'b0;
                    end
                end
                SHIFT: begin
                    ph_q <= ph_q + 1'b1;
                    // Data moves on the rising clock so it stands still across the
                    // falling edge; the far end samples both pins through the same
                    // synchroniser, and a change on the fall would arrive with it.
                    if (ph_q == 2'd1) begin
                        sck_q <= 1'b1;
                        if (bit_q != '0) txs_q <= {txs_q[14:0], 1'b0};
                    end
                    if (ph_q == 2'd3) begin
                        sck_q <= 1'b0;
                        rxd_q <= {rxd_q[14:0], sdo_sync_q[1]};
                        bit_q <= bit_q + 1'b1;
                        if (bit_q == OSS_CNT_W'(OSS_FRAME_BITS - 1)) begin
                            st_q <= GAP;
                        end
                    end
                end
                GAP: begin
                    sel_n_q <= 1'b1;
                    if (sel_n_q) begin
                        done_q <= 1'b1;
                        st_q <= IDLE;
                        tmr_q <= OSS_TIMER_W'(OSS_GAP_CYC);
                    end
                end
                default: st_q <= IDLE;
            endcase
        end
    end

    assign link.sck = sck_q;
    assign link.sel_n = sel_n_q;
    assign link.serial_cmd_in = txs_q[15];
    assign link.enable = en_q;

endmodule : oss_host

//--- bench/oss_chk.sv
`timescale 1ns/1ns
module oss_chk (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Link signals
    input wire logic sel_n,
    input wire logic sck,
    input wire logic sdo_oe,
    input wire logic enable,
    input wire logic sdo_wire
);
    // ----------------------------------------------------------------
    // Frame bookkeeping
    // ----------------------------------------------------------------
    logic sck_q;
    logic [4:0] falls_q;
    logic fall_seen;

    // A falling serial clock as seen by the system clock.
    assign fall_seen = sck_q && !sck;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (srst_in);

    // The count survives until select is sampled high, so the close can read it.
    always_ff @(posedge clk_sys_in) begin
        sck_q <= sck;
        if (srst_in || sel_n) begin
            falls_q <= 5'h00;
        end else if (fall_seen) begin
            falls_q <= falls_q + 5'h01;
        end
    end

    sequence s_open;
        $fell(sel_n);
    endsequence
    sequence s_close;
        $rose(sel_n);
    endsequence

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_open_sck_low: assert property (s_open |-> !sck)
        else $error("sck high when select fell");
    a_close_sck_low: assert property (s_close |-> !sck)
        else $error("sck high when select rose");
    a_idle_sck_low: assert property (sel_n |-> !sck)
        else $error("sck moved while deselected");
    a_sixteen_bits: assert property (s_close |-> falls_q == 5'd16)
        else $error("frame did not hold sixteen clocks");
    a_frame_length: assert property (s_open |-> ##[32:400] s_close)
        else $error("frame did not close in time");
    a_frame_drive: assert property ((!sel_n && enable) [*4] |-> sdo_oe)
        else $error("data out not driven in frame");
    a_idle_release: assert property (sel_n [*4] |-> !sdo_oe)
        else $error("data out driven while deselected");
    a_sleep_release: assert property (!enable [*4] |-> !sdo_oe)
        else $error("data out driven while disabled");
    a_pad_zero: assert property (fall_seen && !sel_n && falls_q < 5'd8 |-> !sdo_wire)
        else $error("status pad bit not zero");
endmodule : oss_chk

//--- bench/oss_tb_top.sv
`timescale 1ns/1ns
module octal_switch_spi_control_tb_top
    import oss_pkg::*;
;
    // ----------------------------------------------------------------
    // Harness
    // ----------------------------------------------------------------
    logic clk_sys_in;
    logic srst_in;
    logic wb_cyc;
    logic wb_stb;
    logic wb_we;
    logic [3:0] wb_adr;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic [7:0] open_fault;
    logic [7:0] short_fault;
    logic [7:0] chan_on;
    logic [7:0] detect_on;
    logic [31:0] outs;
    logic [31:0] q;
    logic [15:0] applied;
    logic [15:0] wire_cmd;
    int wire_bits;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;

    assign outs = {16'h0000, detect_on, chan_on};

    oss_link_if link ();
    oss_host i_oss_host (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(link));
    // A short fault filter keeps the run brief.
    oss_device #(.FAULT_CYC(8)) i_oss_device (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .link(link), .open_fault_in(open_fault), .short_fault_in(short_fault),
        .chan_on_out(chan_on), .detect_on_out(detect_on));
    oss_chk i_oss_chk (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .sel_n(link.sel_n),
        .sck(link.sck), .sdo_oe(link.sdo_oe), .enable(link.enable),
        .sdo_wire(link.sdo_wire));

    // The 25 MHz system clock.
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    // Record the command as it crosses the wire at each falling serial clock.
    always @(negedge link.sck) begin
        if (link.sel_n === 1'b0) begin
            wire_cmd <= {wire_cmd[14:0], link.serial_cmd_in};
            wire_bits <= wire_bits + 1;
        end
    end

    // A hung handshake or poll ends the run here rather than spinning forever.
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches = mismatches + 1;
            finish_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= dat;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_sys_in);
    endtask : wb_xfer

    // Start retries until accepted, since wake-up and frame gaps refuse it.
    task automatic frame(input logic [15:0] cmd, input logic [15:0] stat);
        int n;
        n = 0;
        wb_xfer(1'b1, OSS_REG_CMD, 32'(cmd));
        wire_bits = 0;
        do begin
            wb_xfer(1'b1, OSS_REG_CTRL, 32'h0000_0003);
            wb_xfer(1'b0, OSS_REG_STATUS, 32'h0000_0000);
            n++;
            if (q[OSS_STAT_BUSY_BIT] !== 1'b1)
                repeat (50) @(posedge clk_sys_in);
        end while (q[OSS_STAT_BUSY_BIT] !== 1'b1 && n < 400);
        chk("outputs mid frame", 32'(applied), outs);
        do begin
            wb_xfer(1'b0, OSS_REG_STATUS, 32'h0000_0000);
            n++;
        end while (q[OSS_STAT_DONE_BIT] !== 1'b1 && n < 800);
        repeat (8) @(posedge clk_sys_in);
        applied = cmd;
        chk("status word", 32'(stat), 32'(q[15:0]));
        chk("command on wire", 32'(cmd), 32'(wire_cmd));
        chk("bits on wire", 32'h0000_0010, 32'(wire_bits));
        chk("outputs", 32'(cmd), outs);
    endtask : frame

    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        srst_in = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 4'h0;
        wb_wdat = 32'h0000_0000;
        open_fault = 8'h00;
        short_fault = 8'h00;
        applied = 16'h0000;
        wire_bits = 0;
        repeat (6) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        wb_xfer(1'b0, OSS_REG_STATUS, 32'h0000_0000);
        chk("status after reset", 32'h0000_0000, q);
        wb_xfer(1'b0, 4'hc, 32'h0000_0000);
        chk("unmapped read", 32'h0000_0000, q);
        chk("outputs after reset", 32'h0000_0000, outs);
        wb_xfer(1'b1, OSS_REG_CTRL, 32'h0000_0003);
        wb_xfer(1'b0, OSS_REG_STATUS, 32'h0000_0000);
        chk("start before wake", 32'h0000_0000, q);
        frame(16'ha55a, 16'h0000);
        // A fault shorter than the filter must stay hidden.
        short_fault <= 8'h40;
        repeat (4) @(posedge clk_sys_in);
        short_fault <= 8'h04;
        open_fault <= 8'h81;
        frame(16'h00f0, 16'h0085);
        wb_xfer(1'b1, OSS_REG_CTRL, 32'h0000_0000);
        repeat (10) @(posedge clk_sys_in);
        chk("outputs asleep", 32'h0000_0000, outs);
        applied = 16'h0000;
        wb_xfer(1'b1, OSS_REG_CTRL, 32'h0000_0002);
        frame(16'h0300, 16'h0000);
        frame(16'h0000, 16'h0001);
        finish_test();
    end
endmodule : octal_switch_spi_control_tb_top
